// ---- common/pwm_unit_map.svh ----
/*
  register offsets, field positions, reset values, the pwm mode code and the fine-bit width for the pwm unit.
  assumes inclusion by bare name from the design and bench files; the package does not include it.
*/
`ifndef PWM_UNIT_MAP_SVH
`define PWM_UNIT_MAP_SVH

// byte addresses on the apb bus
`define PWM_OFF_DUTY_VALUE 12'h000
`define PWM_OFF_DUTY_SHADOW 12'h004
`define PWM_OFF_UNIT_CONTROL 12'h008
`define PWM_OFF_PERIOD_LIMIT 12'h00C
`define PWM_OFF_TIMER_CTRL 12'h010
`define PWM_OFF_TIMER_COUNT 12'h014

// unit control field positions
`define PWM_CTL_DUTY_LSB_HI 5
`define PWM_CTL_DUTY_LSB_LO 4
`define PWM_CTL_MODE_HI 3
`define PWM_CTL_MODE_LO 0

// timer control field positions
`define PWM_TCTL_ON_BIT 2
`define PWM_TCTL_PRE_HI 1
`define PWM_TCTL_PRE_LO 0

// reset values
`define PWM_RST_BYTE 8'h00
`define PWM_RST_PERIOD 8'hFF
`define PWM_RST_TCTL 3'h0

// pwm mode codes: 11xx selects pwm
`define PWM_MODE_PWM_TOP 2'h3

// fine-count widths: fine bits below the timer
`define PWM_FINE_BITS 2

`endif

// ---- common/pwm_unit_pkg.sv ----
/*
  types shared by the pwm unit files.
  assumes the map header sits in the include path.
*/
package pwm_unit_pkg;

  // apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  // cycle phase of the pwm output
  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } pwm_phase_e;

  typedef logic [7:0] byte_t;

endpackage

// ---- rtl/pwm_fine_counter.sv ----
/*
  period timer with prescaler and two fine bits below the timer count.
  assumes one clock; period match is decided here against period_in.
*/
`timescale 1ns/10ps
`include "pwm_unit_map.svh"

module pwm_fine_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // control
  input wire logic run_in,
  input wire logic [1:0] prescale_in,
  input wire logic [WIDTH-1:0] period_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_val_in,
  // state
  output logic [WIDTH-1:0] count_out,
  output logic [1:0] fine_out,
  output logic tick_out,
  output logic match_tick_out
);

  logic [3:0] pre_reg, pre_next; // divider below the fine bits
  logic [1:0] fine_reg, fine_next;
  logic [WIDTH-1:0] cnt_reg, cnt_next;
  logic step; // one fine step

  // fine step rate: 1, 4 or 16 clocks per fine step
  function automatic logic pre_done(input logic [1:0] sel, input logic [3:0] p);
    case (sel)
      2'd0: pre_done = 1'b1;
      2'd1: pre_done = (p[1:0] == 2'd3);
      default: pre_done = (p == 4'hF);
    endcase
  endfunction

  assign step = run_in && pre_done(prescale_in, pre_reg);
  // timer increments when the fine bits wrap
  assign tick_out = step && (fine_reg == 2'd3);
  assign match_tick_out = tick_out && (cnt_reg == period_in);

  // next-state of divider, fine bits and timer
  always_comb begin
    pre_next = pre_reg;
    fine_next = fine_reg;
    cnt_next = cnt_reg;
    if (run_in) begin
      pre_next = step ? 4'h0 : pre_reg + 4'h1;
    end
    if (step) begin
      fine_next = fine_reg + 2'd1;
    end
    if (load_in) begin
      cnt_next = load_val_in; // software write wins
    end else if (match_tick_out) begin
      cnt_next = '0;
    end else if (tick_out) begin
      cnt_next = cnt_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pre_reg <= 4'h0;
      fine_reg <= 2'd0;
      cnt_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      fine_reg <= fine_next;
      cnt_reg <= cnt_next;
    end
  end

  assign count_out = cnt_reg;
  assign fine_out = fine_reg;

endmodule

// ---- rtl/pwm_period_duty_unit.sv ----
/*
  pwm unit: apb register file, period timer, double-buffered 10-bit duty and output latch.
  assumes an apb master on clk_sys_in and a port pin whose direction software sets.
*/
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "pwm_unit_map.svh"

// Functional notes
// R1 - pwm waveform on pin, up to 10-bit duty
// R2 - software sets pin direction to output
// R3 - control write zero clears output latch only
// R4 - period limit register sets the period
// R5 - match clears timer at next increment
// R6 - match sets output unless duty zero
// R7 - match copies duty into shadow register
// R8 - control: duty lsbs 5:4, mode 3:0
// R9 - duty is value byte plus control lsbs
// R10 - clear output when shadow equals timer plus fine
// R11 - duty beyond period keeps output high
// R12 - shadow read-only while in pwm mode
// R13 - control register resets to zero
module pwm_period_duty_unit (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pin
  output logic pwm_output_pin_out,
  output logic pwm_mode_active_out
);

  pwm_unit_pkg::apb_req_s req;
  logic wr_en; // write access phase
  logic rd_en; // read access phase

  // registers
  pwm_unit_pkg::byte_t duty_value_reg, duty_value_next;
  pwm_unit_pkg::byte_t duty_shadow_reg, duty_shadow_next;
  logic [1:0] shadow_lsb_reg, shadow_lsb_next; // 2-bit internal latch
  logic [5:0] unit_control_reg, unit_control_next; // bits 7:6 not stored
  pwm_unit_pkg::byte_t period_limit_reg, period_limit_next;
  logic [2:0] timer_ctrl_reg, timer_ctrl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic out_reg, out_next;
  pwm_unit_pkg::pwm_phase_e phase_reg, phase_next;

  // timer signals
  pwm_unit_pkg::byte_t tmr_count;
  logic [1:0] tmr_fine;
  logic tmr_tick;
  logic period_tick;
  logic tmr_load;
  logic pwm_mode;
  logic [9:0] duty_full;
  logic [9:0] duty_next_full;
  logic [9:0] time_full;

  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in, wdata: pwdata_in};
  assign wr_en = req.sel && req.enable && req.write;
  assign rd_en = req.sel && req.enable && !req.write;

  // known-offset check used by the error response to both reads and writes
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `PWM_OFF_DUTY_VALUE) || (a == `PWM_OFF_DUTY_SHADOW)
              || (a == `PWM_OFF_UNIT_CONTROL) || (a == `PWM_OFF_PERIOD_LIMIT)
              || (a == `PWM_OFF_TIMER_CTRL) || (a == `PWM_OFF_TIMER_COUNT);
  endfunction

  // pwm selected by mode code 11xx
  assign pwm_mode = (unit_control_reg[`PWM_CTL_MODE_HI:`PWM_CTL_MODE_HI-1] == `PWM_MODE_PWM_TOP);
  assign tmr_load = wr_en && (req.addr == `PWM_OFF_TIMER_COUNT);

  // period timer with fine bits
  pwm_fine_counter #(
    .WIDTH(8)
  ) pwm_fine_counter_i (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .run_in(timer_ctrl_reg[`PWM_TCTL_ON_BIT]),
    .prescale_in(timer_ctrl_reg[`PWM_TCTL_PRE_HI:`PWM_TCTL_PRE_LO]),
    .period_in(period_limit_reg), // R4
    .load_in(tmr_load),
    .load_val_in(req.wdata[7:0]),
    .count_out(tmr_count),
    .fine_out(tmr_fine),
    .tick_out(tmr_tick),
    .match_tick_out(period_tick) // R5
  );

  // 10-bit duty: value byte over control lsbs
  assign duty_next_full = {duty_value_reg, unit_control_reg[`PWM_CTL_DUTY_LSB_HI:`PWM_CTL_DUTY_LSB_LO]}; // R9
  assign duty_full = {duty_shadow_reg, shadow_lsb_reg};
  assign time_full = {tmr_count, tmr_fine}; // R10

  // register writes and shadow reload
  always_comb begin
    duty_value_next = duty_value_reg;
    duty_shadow_next = duty_shadow_reg;
    shadow_lsb_next = shadow_lsb_reg;
    unit_control_next = unit_control_reg;
    period_limit_next = period_limit_reg;
    timer_ctrl_next = timer_ctrl_reg;
    if (wr_en) begin
      unique case (req.addr)
        `PWM_OFF_DUTY_VALUE: begin
          duty_value_next = req.wdata[7:0];
        end
        `PWM_OFF_DUTY_SHADOW: begin
          // shadow ignores writes in pwm mode
          if (!pwm_mode) begin // R12
            duty_shadow_next = req.wdata[7:0];
          end
        end
        `PWM_OFF_UNIT_CONTROL: begin
          unit_control_next = req.wdata[5:0]; // R8
        end
        `PWM_OFF_PERIOD_LIMIT: begin
          period_limit_next = req.wdata[7:0]; // R4
        end
        `PWM_OFF_TIMER_CTRL: begin
          timer_ctrl_next = req.wdata[2:0];
        end
        default: begin
          // timer count handled in the counter, others ignored
        end
      endcase
    end
    // reload at cycle boundary; beats a shadow write in the same cycle
    if (pwm_mode && period_tick) begin
      duty_shadow_next = duty_value_reg; // R7
      shadow_lsb_next = unit_control_reg[`PWM_CTL_DUTY_LSB_HI:`PWM_CTL_DUTY_LSB_LO]; // R7
    end
  end

  // output latch and phase
  always_comb begin
    out_next = out_reg;
    phase_next = phase_reg;
    if (!pwm_mode) begin
      // a control of zero (or any non-pwm code) leaves the latch low
      out_next = 1'b0; // R3
      phase_next = pwm_unit_pkg::PH_LOW;
    end else if (period_tick) begin
      // new cycle: high unless the next duty is zero
      out_next = (duty_next_full != 10'h000); // R6
      phase_next = (duty_next_full != 10'h000) ? pwm_unit_pkg::PH_HIGH : pwm_unit_pkg::PH_LOW;
    end else if ((phase_reg == pwm_unit_pkg::PH_HIGH) && (duty_full == time_full)) begin
      // duty beyond period never matches, so the output stays high
      out_next = 1'b0; // R10 R11
      phase_next = pwm_unit_pkg::PH_LOW;
    end
  end

  // read mux and error response
  always_comb begin
    prdata_next = prdata_reg;
    // hold the error through the access edge so it cannot change as it is sampled
    pslverr_next = (req.sel && req.enable) ? pslverr_reg : 1'b0;
    if (req.sel && !req.enable) begin
      prdata_next = 32'h0000_0000;
      if (!req.write) begin
        unique case (req.addr)
          `PWM_OFF_DUTY_VALUE: prdata_next = {24'h00_0000, duty_value_reg};
          `PWM_OFF_DUTY_SHADOW: prdata_next = {24'h00_0000, duty_shadow_reg};
          `PWM_OFF_UNIT_CONTROL: prdata_next = {26'h000_0000, unit_control_reg}; // R8
          `PWM_OFF_PERIOD_LIMIT: prdata_next = {24'h00_0000, period_limit_reg};
          `PWM_OFF_TIMER_CTRL: prdata_next = {29'h0000_0000, timer_ctrl_reg};
          `PWM_OFF_TIMER_COUNT: prdata_next = {24'h00_0000, tmr_count};
          default: prdata_next = 32'h0000_0000;
        endcase
      end
      pslverr_next = !addr_known(req.addr);
    end
  end

  // single register stage for all state outside the timer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      duty_value_reg <= `PWM_RST_BYTE;
      duty_shadow_reg <= `PWM_RST_BYTE;
      shadow_lsb_reg <= 2'h0;
      unit_control_reg <= 6'h00; // R13
      period_limit_reg <= `PWM_RST_PERIOD;
      timer_ctrl_reg <= `PWM_RST_TCTL;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      out_reg <= 1'b0;
      phase_reg <= pwm_unit_pkg::PH_LOW;
    end else begin
      duty_value_reg <= duty_value_next;
      duty_shadow_reg <= duty_shadow_next;
      shadow_lsb_reg <= shadow_lsb_next;
      unit_control_reg <= unit_control_next;
      period_limit_reg <= period_limit_next;
      timer_ctrl_reg <= timer_ctrl_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      out_reg <= out_next;
      phase_reg <= phase_next;
    end
  end

  // data captured in setup, so the access phase always completes at once
  assign pready_out = 1'b1;
  assign prdata_out = rd_en ? prdata_reg : 32'h0000_0000;
  assign pslverr_out = req.sel && req.enable && pslverr_reg;
  // pin direction is the port's business, outside this unit
  assign pwm_output_pin_out = out_reg; // R1
  assign pwm_mode_active_out = pwm_mode;

  // checks
  property p_ctl_zero_low;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (wr_en && req.addr == `PWM_OFF_UNIT_CONTROL && req.wdata[3:0] == 4'h0) |=> ##1 !pwm_output_pin_out;
  endproperty
  a_ctl_zero_low: assert property (p_ctl_zero_low) else $error("latch not low after control cleared"); // R3

  property p_match_clear;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (period_tick && !tmr_load) |=> (tmr_count == 8'h00);
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("timer not cleared on period match"); // R5

  // timer counts up by one per tick below the period limit
  property p_timer_step;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (tmr_tick && !period_tick && !tmr_load) |=> (tmr_count == $past(tmr_count) + 8'h01);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not step on tick"); // R4

  property p_match_set;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pwm_mode && period_tick) |=> (pwm_output_pin_out == ($past(duty_next_full) != 10'h000));
  endproperty
  a_match_set: assert property (p_match_set) else $error("output wrong at cycle start"); // R6

  property p_reload;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pwm_mode && period_tick) |=> (duty_full == $past(duty_next_full));
  endproperty
  a_reload: assert property (p_reload) else $error("shadow not reloaded at match"); // R7 R9

  property p_ctl_read;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (rd_en && req.addr == `PWM_OFF_UNIT_CONTROL) |-> (prdata_out[31:6] == 26'h000_0000);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("unused control bits read non-zero"); // R8

  property p_fall;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pwm_mode && out_reg && !period_tick && duty_full == time_full) |=> !pwm_output_pin_out;
  endproperty
  a_fall: assert property (p_fall) else $error("output not cleared at duty match"); // R10

  property p_long_duty;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pwm_mode && out_reg && !period_tick && duty_full > {period_limit_reg, 2'b11}
        && $stable(unit_control_reg)) |=> pwm_output_pin_out;
  endproperty
  a_long_duty: assert property (p_long_duty) else $error("output fell with duty beyond period"); // R11

  property p_shadow_ro;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pwm_mode && !period_tick) |=> $stable(duty_shadow_reg);
  endproperty
  a_shadow_ro: assert property (p_shadow_ro) else $error("shadow changed in pwm mode off a boundary"); // R12

  property p_out_needs_mode;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      pwm_output_pin_out |-> $past(pwm_mode);
  endproperty
  a_out_needs_mode: assert property (p_out_needs_mode) else $error("output high outside pwm mode"); // R1 R13

  c_period: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) pwm_mode && period_tick);
  c_fall: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) $fell(pwm_output_pin_out) && pwm_mode);
  c_zero_duty: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pwm_mode && period_tick && duty_next_full == 10'h000);
  c_shadow_blocked: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pwm_mode && wr_en && req.addr == `PWM_OFF_DUTY_SHADOW);

endmodule

// ---- verif/tb_pwm_period_duty_unit.sv ----
/*
  self-checking bench for the pwm unit: apb register access, waveform shape, duty buffering.
  assumes the map header in the include path and a slave on the same clock.
*/
`timescale 1ns/10ps
`include "pwm_unit_map.svh"

module tb_pwm_period_duty_unit;
  // design inputs
  logic clk_sys_in;
  logic sys_rst_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  // design outputs
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic pwm_output_pin_out;
  logic pwm_mode_active_out;
  // bookkeeping
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic err;
  int h;

  pwm_period_duty_unit pwm_period_duty_unit_i (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .pwm_output_pin_out(pwm_output_pin_out),
    .pwm_mode_active_out(pwm_mode_active_out)
  );

  // free-running 125 mhz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // single exit point of the run
  task give_verdict;
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // exact compare, four-state
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // range compare: registered compare may add one clock per pulse
  task check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  // a bounded wait ran out
  task timeout;
    miscompares++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
    give_verdict();
  endtask

  // one apb transfer; answer taken at the edge where pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    // access phase lasts until pready is seen high at a rising edge
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 16) timeout();
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    // let the edge's register updates settle before the caller looks
    @(negedge clk_sys_in);
  endtask

  // read and compare data and error flag
  task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check({31'h0000_0000, err}, {31'h0000_0000, e});
  endtask

  // wait for a number of rising edges of the pin, bounded
  task wait_rise(input int n_rises);
    int k;
    int seen;
    logic prev;
    seen = 0;
    prev = pwm_output_pin_out;
    for (k = 0; k < 5000 && seen < n_rises; k++) begin
      @(negedge clk_sys_in);
      if (prev === 1'b0 && pwm_output_pin_out === 1'b1) seen++;
      prev = pwm_output_pin_out;
    end
    if (seen < n_rises) timeout();
  endtask

  // count high cycles of the pin over a window
  task count_high(input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(negedge clk_sys_in);
      if (pwm_output_pin_out === 1'b1) hi++;
    end
  endtask

  // stop timer, clear it, program period and duty, enter pwm mode, start
  task setup_pwm(input logic [7:0] lim, input logic [7:0] val, input logic [1:0] lsb, input logic [1:0] pre);
    apb(1'b1, `PWM_OFF_TIMER_CTRL, 32'h0000_0000);
    apb(1'b1, `PWM_OFF_TIMER_COUNT, 32'h0000_0000);
    apb(1'b1, `PWM_OFF_PERIOD_LIMIT, {24'h00_0000, lim});
    apb(1'b1, `PWM_OFF_DUTY_VALUE, {24'h00_0000, val});
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, {26'h000_0000, lsb, 4'hC});
    apb(1'b1, `PWM_OFF_TIMER_CTRL, {29'h0000_0000, 1'b1, pre});
  endtask

  // reset values and an unmapped address
  task t_reset;
    check({31'h0000_0000, pwm_output_pin_out}, 32'h0000_0000);
    check({31'h0000_0000, pready_out}, 32'h0000_0001);
    rdchk(`PWM_OFF_DUTY_VALUE, 32'h0000_0000, 1'b0);
    rdchk(`PWM_OFF_DUTY_SHADOW, 32'h0000_0000, 1'b0);
    rdchk(`PWM_OFF_UNIT_CONTROL, 32'h0000_0000, 1'b0);
    rdchk(`PWM_OFF_PERIOD_LIMIT, 32'h0000_00FF, 1'b0);
    rdchk(`PWM_OFF_TIMER_CTRL, 32'h0000_0000, 1'b0);
    rdchk(`PWM_OFF_TIMER_COUNT, 32'h0000_0000, 1'b0);
    rdchk(12'h018, 32'h0000_0000, 1'b1);
  endtask

  // control layout: bits 7:6 read zero, mode bits select pwm
  task t_control;
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, 32'h0000_00FF);
    rdchk(`PWM_OFF_UNIT_CONTROL, 32'h0000_003F, 1'b0);
    check({31'h0000_0000, pwm_mode_active_out}, 32'h0000_0001);
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, 32'h0000_0008);
    check({31'h0000_0000, pwm_mode_active_out}, 32'h0000_0000);
    // a stopped timer takes a loaded count and reads it back
    apb(1'b1, `PWM_OFF_TIMER_COUNT, 32'h0000_0005);
    rdchk(`PWM_OFF_TIMER_COUNT, 32'h0000_0005, 1'b0);
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, 32'h0000_0000);
  endtask

  // waveform shape over a table of period, duty and prescale
  task t_waveform;
    logic [7:0] lim [4];
    logic [7:0] val [4];
    logic [1:0] lsb [4];
    logic [1:0] pre [4];
    int s;
    int d;
    int per;
    lim = '{8'h01, 8'h03, 8'h01, 8'h01};
    val = '{8'h00, 8'h01, 8'h00, 8'h00};
    lsb = '{2'h2, 2'h1, 2'h2, 2'h2};
    pre = '{2'h0, 2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin
      s = (pre[i] == 2'h0) ? 1 : ((pre[i] == 2'h1) ? 4 : 16);
      d = {val[i], lsb[i]};
      per = (lim[i] + 1) * 4 * s;
      setup_pwm(lim[i], val[i], lsb[i], pre[i]);
      // skip the first period, whose shadow may be stale
      wait_rise(2);
      count_high(4 * per, h);
      check_range(h, 4 * d * s, 4 * d * s + 4);
    end
  endtask

  // duty zero keeps low; duty beyond period keeps high; clearing control forces low
  task t_limits;
    setup_pwm(8'h01, 8'h00, 2'h0, 2'h0);
    count_high(40, h);
    count_high(32, h);
    check(h, 32'h0000_0000);
    setup_pwm(8'h01, 8'h03, 2'h0, 2'h0);
    count_high(40, h);
    count_high(32, h);
    check(h, 32'h0000_0020);
    check({31'h0000_0000, pwm_mode_active_out}, 32'h0000_0001);
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, 32'h0000_0000);
    count_high(2, h);
    check({31'h0000_0000, pwm_output_pin_out}, 32'h0000_0000);
    rdchk(`PWM_OFF_DUTY_VALUE, 32'h0000_0003, 1'b0);
  endtask

  // duty takes effect only at period match; shadow locked in pwm mode
  task t_buffer;
    setup_pwm(8'h40, 8'h10, 2'h0, 2'h0);
    wait_rise(2);
    apb(1'b1, `PWM_OFF_DUTY_VALUE, 32'h0000_0020);
    rdchk(`PWM_OFF_DUTY_SHADOW, 32'h0000_0010, 1'b0);
    apb(1'b1, `PWM_OFF_DUTY_SHADOW, 32'h0000_0055);
    rdchk(`PWM_OFF_DUTY_SHADOW, 32'h0000_0010, 1'b0);
    wait_rise(1);
    rdchk(`PWM_OFF_DUTY_SHADOW, 32'h0000_0020, 1'b0);
    // outside pwm mode the shadow is writable
    apb(1'b1, `PWM_OFF_UNIT_CONTROL, 32'h0000_0000);
    apb(1'b1, `PWM_OFF_DUTY_SHADOW, 32'h0000_0066);
    rdchk(`PWM_OFF_DUTY_SHADOW, 32'h0000_0066, 1'b0);
  endtask

  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_control();
    t_waveform();
    t_limits();
    t_buffer();
    give_verdict();
  end
endmodule
